// ### pkg/dacsw_defs.vh
`ifndef DACSW_DEFS_VH
`define DACSW_DEFS_VH
// frame layout
`define DACSW_FRAME_BITS 16
`define DACSW_FRAME_LAST 5'h0F
`define DACSW_MODE_HI_POS 13
`define DACSW_MODE_LO_POS 12
`define DACSW_DATA_MSB 11
`define DACSW_DATA_LSB 2
`define DACSW_DATA_W 10
// modes
`define DACSW_MODE_NORMAL 2'h0
`define DACSW_MODE_PD_1K 2'h1
`define DACSW_MODE_PD_100K 2'h2
`define DACSW_MODE_PD_OPEN 2'h3
// reset values
`define DACSW_CODE_RST 10'h000
`define DACSW_MODE_RST 2'h0
// timing
`define DACSW_CLK_MHZ 100
`define DACSW_LINK_MAX_MHZ 30
`define DACSW_SEL_HIGH_NS 33
`endif

// ### rtl/dacsw_sync2.v
`timescale 1ns/1ps
// two-stage synchroniser for pins
module dacsw_sync2
(
	input wire ref_clk_in,
	input wire rst_in,
	input wire d_in,
	output reg q_out
);
	reg meta_q;
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_q <= 1'b1;
			q_out <= 1'b1;
		end
		else
		begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end
endmodule

// ### rtl/dacsw_top.v
`timescale 1ns/1ps
`include "dacsw_defs.vh"
module dacsw_top
(
	input wire ref_clk_in,
	input wire rst_in,
	input wire frame_sel_n_in,
	input wire shift_clk_in,
	input wire ser_data_in,
	output reg [9:0] dac_code_out,
	output reg [1:0] op_mode_out,
	output reg amp_connect_out,
	output reg term_1k_out,
	output reg term_100k_out,
	output reg frame_done_out,
	output reg frame_abort_out
);
	// 100 MHz sampling of a 30 MHz link leaves ~3 samples a period;
	// a faster host would lose edges
	wire sel_n_s;
	wire sclk_s;
	wire sdat_s;
	wire sclk_fall;
	wire sel_fall;
	wire sel_rise;
	reg sel_n_prev_q;
	reg sclk_prev_q;
	reg [15:0] shift_q;
	reg [15:0] shift_d;
	reg [4:0] count_q;
	reg [4:0] count_d;
	reg done_q;
	reg done_d;
	reg [15:0] frame_w;
	reg [9:0] code_d;
	reg [1:0] mode_d;
	reg amp_d;
	reg term_1k_d;
	reg term_100k_d;
	reg done_pulse_d;
	reg abort_pulse_d;

	// mode field of an assembled frame
	function [1:0] mode_of;
		input [15:0] frame;
		begin
			mode_of = {frame[`DACSW_MODE_HI_POS], frame[`DACSW_MODE_LO_POS]};
		end
	endfunction

	// code field, straight binary
	function [9:0] code_of;
		input [15:0] frame;
		begin
			code_of = frame[`DACSW_DATA_MSB:`DACSW_DATA_LSB];
		end
	endfunction

	// mode compare, shared by the amplifier and both terminations
	function is_mode;
		input [1:0] mode;
		input [1:0] want;
		begin
			is_mode = (mode == want);
		end
	endfunction

	dacsw_sync2 u_sel
	(
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.d_in(frame_sel_n_in),
		.q_out(sel_n_s)
	);
	dacsw_sync2 u_clk
	(
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.d_in(shift_clk_in),
		.q_out(sclk_s)
	);
	dacsw_sync2 u_dat
	(
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.d_in(ser_data_in),
		.q_out(sdat_s)
	);

	// reset levels match the idle pins, so no false edge follows reset
	assign sclk_fall = sclk_prev_q & ~sclk_s;
	assign sel_fall = sel_n_prev_q & ~sel_n_s;
	assign sel_rise = ~sel_n_prev_q & sel_n_s;

	// msb first: new bit enters at the bottom
	always @*
	begin
		frame_w = {shift_q[14:0], sdat_s};
	end

	always @*
	begin
		shift_d = shift_q;
		count_d = count_q;
		done_d = done_q;
		code_d = dac_code_out;
		mode_d = op_mode_out;
		amp_d = amp_connect_out;
		term_1k_d = term_1k_out;
		term_100k_d = term_100k_out;
		done_pulse_d = 1'b0;
		abort_pulse_d = 1'b0;
		if (sel_n_s)
		begin
			// select high: shift clock edges ignored; a rise mid-frame clears the shift register and aborts
			if (sel_rise && !done_q)
			begin
				shift_d = 16'h0000;
				abort_pulse_d = (count_q != 5'h00);
			end
			count_d = 5'h00;
			done_d = 1'b0;
		end
		else if (sel_fall)
		begin
			count_d = 5'h00;
			done_d = 1'b0;
			shift_d = 16'h0000;
		end
		else if (sclk_fall && !done_q)
		begin
			shift_d = frame_w;
			count_d = count_q + 5'h01;
			if (count_q == `DACSW_FRAME_LAST)
			begin
				// apply on the 16th fall, bits 15:14 and 1:0 dropped
				done_d = 1'b1;
				done_pulse_d = 1'b1;
				code_d = code_of(frame_w);
				mode_d = mode_of(frame_w);
				// code kept in any mode
				amp_d = is_mode(mode_of(frame_w), `DACSW_MODE_NORMAL);
				term_1k_d = is_mode(mode_of(frame_w), `DACSW_MODE_PD_1K);
				term_100k_d = is_mode(mode_of(frame_w), `DACSW_MODE_PD_100K);
			end
		end
	end

	// link edge detectors
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sel_n_prev_q <= 1'b1;
			sclk_prev_q <= 1'b1;
		end
		else
		begin
			sel_n_prev_q <= sel_n_s;
			sclk_prev_q <= sclk_s;
		end
	end

	// frame state: shift register, bit count, applied flag
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			shift_q <= 16'h0000;
			count_q <= 5'h00;
			done_q <= 1'b0;
		end
		else
		begin
			shift_q <= shift_d;
			count_q <= count_d;
			done_q <= done_d;
		end
	end

	// outputs held until the next applied frame or reset, except the one-cycle done and abort pulses
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			dac_code_out <= `DACSW_CODE_RST;
			op_mode_out <= `DACSW_MODE_RST;
			amp_connect_out <= 1'b1;
			term_1k_out <= 1'b0;
			term_100k_out <= 1'b0;
			frame_done_out <= 1'b0;
			frame_abort_out <= 1'b0;
		end
		else
		begin
			dac_code_out <= code_d;
			op_mode_out <= mode_d;
			amp_connect_out <= amp_d;
			term_1k_out <= term_1k_d;
			term_100k_out <= term_100k_d;
			frame_done_out <= done_pulse_d;
			frame_abort_out <= abort_pulse_d;
		end
	end
endmodule

// ### verification/dacsw_host.sv
`timescale 1ns/1ps
module dacsw_host
(
	input wire ref_clk_in,
	output logic sel_n_out = 1'b1,
	output logic sclk_out = 1'b1,
	output logic sdat_out = 1'b0
);
	// 160 ns link period, 8 clocks each half; clock idles high;
	// data inverts once its hold has run out
	task automatic send(input logic [15:0] w, input int n, input logic fin);
		@(posedge ref_clk_in);
		sel_n_out <= 1'b1;
		repeat (5) @(posedge ref_clk_in);
		sel_n_out <= 1'b0;
		for (int i = 15; i > 15 - n; i--)
		begin
			sdat_out <= w[i[3:0]];
			repeat (8) @(posedge ref_clk_in);
			sclk_out <= 1'b0;
			repeat (4) @(posedge ref_clk_in);
			sdat_out <= ~sdat_out;
			repeat (4) @(posedge ref_clk_in);
			sclk_out <= 1'b1;
		end
		repeat (8) @(posedge ref_clk_in);
		sel_n_out <= fin;
		@(negedge ref_clk_in);
	endtask
	// shift clock running while select stays high
	task automatic stray(input int n);
		for (int i = 0; i < n; i++)
		begin
			repeat (8) @(posedge ref_clk_in);
			sclk_out <= 1'b0;
			sdat_out <= ~sdat_out;
			repeat (8) @(posedge ref_clk_in);
			sclk_out <= 1'b1;
		end
		@(negedge ref_clk_in);
	endtask
endmodule

// ### verification/dacsw_monitor.sv
`timescale 1ns/1ps
module dacsw_monitor
(
	input wire ref_clk_in,
	input wire rst_in,
	input wire frame_sel_n_in,
	input wire [9:0] dac_code_out,
	input wire [1:0] op_mode_out,
	input wire amp_connect_out,
	input wire term_1k_out,
	input wire term_100k_out,
	input wire frame_done_out,
	input wire frame_abort_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	a_amp_mode: assert property (amp_connect_out == (op_mode_out == 2'h0)) else $error("amp");
	a_term_low: assert property (term_1k_out == (op_mode_out == 2'h1)) else $error("1k");
	a_term_high: assert property (term_100k_out == (op_mode_out == 2'h2)) else $error("100k");
	a_code_hold: assert property (!frame_done_out |-> $stable(dac_code_out)) else $error("code");
	a_mode_hold: assert property (!frame_done_out |-> $stable(op_mode_out)) else $error("mode");
	a_done_once: assert property (frame_done_out |=> (!frame_done_out)[*8]) else $error("twice");
	a_abort_alone: assert property (frame_abort_out |-> !frame_done_out) else $error("both");
	// eight high cycles outlast the pin synchroniser
	a_idle_quiet: assert property (frame_sel_n_in[*8] |-> !frame_done_out) else $error("idle");
	c_open: cover property (frame_done_out && op_mode_out == 2'h3);
	c_abort: cover property (frame_abort_out);
	c_full: cover property (frame_done_out && dac_code_out == 10'h3FF);
endmodule
bind dacsw_top dacsw_monitor mon_u (.*);

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	wire frame_sel_n_in, shift_clk_in, ser_data_in, amp_connect_out, term_1k_out, term_100k_out;
	wire frame_done_out, frame_abort_out;
	wire [9:0] dac_code_out;
	wire [1:0] op_mode_out;
	wire [14:0] outs = {op_mode_out, dac_code_out, amp_connect_out, term_1k_out, term_100k_out};
	int bad_count, comparisons, cyc, dones, aborts;
	dacsw_top dut_u (.*);
	dacsw_host host_u (.ref_clk_in(ref_clk_in), .sel_n_out(frame_sel_n_in),
		.sclk_out(shift_clk_in), .sdat_out(ser_data_in));
	initial forever #5 ref_clk_in = ~ref_clk_in;
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [14:0] got, input logic [14:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [14:0] st(input logic [1:0] m, input logic [9:0] c);
		return {m, c, m == 2'h0, m == 2'h1, m == 2'h2};
	endfunction
	always @(posedge ref_clk_in)
	begin
		dones += frame_done_out;
		aborts += frame_abort_out;
		if (++cyc == 8000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		cmp(outs, st(2'h0, 10'h000));
		for (int m = 0; m < 4; m++)
		begin
			host_u.send({2'h3, 2'(m), 10'(m * 341), 2'h3}, 16, m[0]);
			cmp(outs, st(2'(m), 10'(m * 341)));
		end
		host_u.send(16'h0000, 15, 1'b1);
		cmp(outs, st(2'h3, 10'h3FF));
		host_u.send(16'h5A5A, 20, 1'b1);
		cmp(outs, st(2'h1, 10'h296));
		host_u.stray(3);
		cmp(outs, st(2'h1, 10'h296));
		host_u.send(16'h02AC, 16, 1'b0);
		cmp(outs, st(2'h0, 10'h0AB));
		cmp(15'(dones), 15'h6);
		cmp(15'(aborts), 15'h1);
		give_verdict();
	end
endmodule
